// File: shared/brg_defs.svh
// offsets, field positions, reset values and counts of the rate generator
`ifndef BRG_DEFS_SVH
`define BRG_DEFS_SVH
`define BRG_ADDR_W     4
`define BRG_OFS_RATE   4'h0
`define BRG_OFS_MODE   4'h4
`define BRG_OFS_STAT   4'h8
`define BRG_OFS_MASK   4'hc
`define BRG_RATE_RST   8'h3f
`define BRG_PSEL_LSB   6
`define BRG_TSEL_LSB   3
`define BRG_RSEL_LSB   0
`define BRG_MODE_WAIT  0
`define BRG_MODE_STOP  1
`define BRG_EV_WAITX   0
`define BRG_EV_STOPX   1
`define BRG_EV_RXDROP  2
`define BRG_EV_TXFRZ   3
`define BRG_EV_W       4
`define BRG_PRE_DIV0   4'd1
`define BRG_PRE_DIV1   4'd3
`define BRG_PRE_DIV2   4'd4
`define BRG_PRE_DIV3   4'd13
`define BRG_OVS_LAST   4'hf
`define BRG_RESP_OKAY  2'b00
`define BRG_RESP_SLV   2'b10
`endif

// File: shared/brg_pkg.sv
// types shared by the rate generator and its bench
package brg_pkg;
  typedef enum logic [2:0] {
    PWR_RUN  = 3'b001,
    PWR_WAIT = 3'b010,
    PWR_STOP = 3'b100
  } brg_pwr_t;
endpackage : brg_pkg

// File: design/brg_top.sv
// baud rate generator with wait/stop handling and axi4-lite registers
//
// Behaviour
// - power-of-two divide 1..128 by 3-bit select
// - rx ticks at 16x, tx bit at baud
// - generator keeps running during wait mode
// - serial interrupt request ends wait mode
// - stop halts generator, drops partial receive
// - stop freezes a transmission in progress
// - external interrupt exit resumes frozen transmission
// - prescaler divides by 1,3,4,13; reset 1
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "brg_defs.svh"

// ----------------------------------------------------------------------
// power-of-two divider
// ----------------------------------------------------------------------
module brg_divider (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       en,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [6:0] cnt;
  logic [6:0] lim;

  // last count is 2^sel - 1
  assign lim  = 7'((8'h01 << sel) - 8'h01);
  assign tick = en && (cnt >= lim);

  // counter holds while en is low, so a halt keeps its phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 7'h00;
    end else if (en) begin
      cnt <= tick ? 7'h00 : 7'(cnt + 7'h01);
    end
  end

  chk_div_wrap: assert property (@(posedge clk) disable iff (rst)
    (en && cnt == 7'h00 && sel == 3'd2) ##1 (en && sel == 3'd2)[*3]
    |-> tick) else $error("divider missed tick after four counts");

  // divide by eight: six enabled cycles after a tick stay quiet
  chk_div_early: assert property (@(posedge clk) disable iff (rst)
    (tick && sel == 3'd3) ##1 (en && sel == 3'd3)[*6] |-> !tick)
    else $error("divider ticked before its last count");
endmodule : brg_divider

// ----------------------------------------------------------------------
// top
// ----------------------------------------------------------------------
module brg_top (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [`BRG_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`BRG_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   ext_irq_n,
  input  wire logic                   sci_irq_req,
  input  wire logic                   tx_busy,
  input  wire logic                   rx_busy,
  output logic                        tx_bit_tick,
  output logic                        rx_sample_tick,
  output logic                        rx_discard,
  output logic                        tx_frozen,
  output brg_pkg::brg_pwr_t           power_state,
  output logic                        irq
);
  import brg_pkg::*;

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  logic [7:0]            rate;
  logic [3:0]            mask;
  logic [3:0]            status;
  logic [3:0]            ev_set;
  logic [3:0]            rd_clr;
  logic [1:0]            prescale_select;
  logic [2:0]            tx_rate_select;
  logic [2:0]            rx_rate_select;
  logic [3:0]            pre_cnt;
  logic [3:0]            pre_last;
  logic                  pre_tick;
  logic                  gen_run;
  logic                  tx_div_tick;
  logic                  rx_div_tick;
  logic [3:0]            ovs_cnt;
  logic                  irq_meta;
  logic                  irq_sync_n;
  logic                  ext_wake;
  logic                  aw_full;
  logic                  w_full;
  logic [`BRG_ADDR_W-1:0] aw_addr;
  logic [7:0]            w_data;
  logic                  w_lane;
  logic                  wr_fire;
  logic                  mode_wr;
  logic                  go_wait;
  logic                  go_stop;
  logic                  rd_take;
  brg_pwr_t              st;
  brg_pwr_t              next_st;

  assign prescale_select = rate[`BRG_PSEL_LSB+1:`BRG_PSEL_LSB];
  assign tx_rate_select  = rate[`BRG_TSEL_LSB+2:`BRG_TSEL_LSB];
  assign rx_rate_select  = rate[`BRG_RSEL_LSB+2:`BRG_RSEL_LSB];
  assign power_state     = st;

  // --------------------------------------------------------------------
  // external interrupt pin synchroniser
  // --------------------------------------------------------------------
  // idle high, so both stages reset to one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_meta   <= 1'b1;
      irq_sync_n <= 1'b1;
    end else begin
      irq_meta   <= ext_irq_n;
      irq_sync_n <= irq_meta;
    end
  end
  assign ext_wake = !irq_sync_n;

  // --------------------------------------------------------------------
  // common prescaler
  // --------------------------------------------------------------------
  // generator runs in run and wait, halts only in stop
  assign gen_run = (st != PWR_STOP);

  // divisor table, select 00 after reset
  always_comb begin
    unique case (prescale_select)
      2'b00: pre_last = 4'(`BRG_PRE_DIV0 - 4'd1);
      2'b01: pre_last = 4'(`BRG_PRE_DIV1 - 4'd1);
      2'b10: pre_last = 4'(`BRG_PRE_DIV2 - 4'd1);
      2'b11: pre_last = 4'(`BRG_PRE_DIV3 - 4'd1);
    endcase
  end

  // >= tolerates a divisor shrinking mid-count
  assign pre_tick = gen_run && (pre_cnt >= pre_last);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= 4'h0;
    end else if (gen_run) begin
      pre_cnt <= pre_tick ? 4'h0 : 4'(pre_cnt + 4'h1);
    end
  end

  chk_pre_thirteen: assert property (@(posedge sys_clk)
    disable iff (rst)
    (pre_tick && prescale_select == 2'b11) ##1
    (gen_run && prescale_select == 2'b11)[*8] |-> !pre_tick)
    else $error("prescaler /13 ticked early");

  chk_pre_three: assert property (@(posedge sys_clk)
    disable iff (rst)
    (pre_tick && prescale_select == 2'b01) ##1
    (gen_run && prescale_select == 2'b01)[*3] |-> pre_tick)
    else $error("prescaler /3 missed its tick");

  // --------------------------------------------------------------------
  // transmit and receive dividers
  // --------------------------------------------------------------------
  // both fed by the same prescaler tick, each with its own select
  brg_divider u_tx_div (
    .clk  (sys_clk),
    .rst  (rst),
    .en   (pre_tick),
    .sel  (tx_rate_select),
    .tick (tx_div_tick)
  );

  brg_divider u_rx_div (
    .clk  (sys_clk),
    .rst  (rst),
    .en   (pre_tick),
    .sel  (rx_rate_select),
    .tick (rx_div_tick)
  );

  chk_div_shared: assert property (@(posedge sys_clk)
    disable iff (rst)
    (tx_div_tick || rx_div_tick) |-> pre_tick)
    else $error("divider ticked without prescaler");

  // divider output is the 16x clock; tx bit is one in sixteen of it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovs_cnt <= 4'h0;
    end else if (tx_div_tick) begin
      ovs_cnt <= 4'(ovs_cnt + 4'h1);
    end
  end

  // registered tick outputs, one cycle behind the dividers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_bit_tick    <= 1'b0;
      rx_sample_tick <= 1'b0;
    end else begin
      tx_bit_tick    <= tx_div_tick && (ovs_cnt == `BRG_OVS_LAST);
      rx_sample_tick <= rx_div_tick;
    end
  end

  chk_tx_sixteen: assert property (@(posedge sys_clk)
    disable iff (rst)
    tx_bit_tick |-> $past(ovs_cnt) == `BRG_OVS_LAST && $past(tx_div_tick))
    else $error("tx bit tick not on sixteenth rate tick");

  // --------------------------------------------------------------------
  // power mode state machine
  // --------------------------------------------------------------------
  assign mode_wr = wr_fire && (aw_addr == `BRG_OFS_MODE) && w_lane;
  assign go_wait = mode_wr && w_data[`BRG_MODE_WAIT]
                   && !w_data[`BRG_MODE_STOP];
  assign go_stop = mode_wr && w_data[`BRG_MODE_STOP];

  always_comb begin
    next_st = st;
    unique case (st)
      PWR_RUN: begin
        if (go_stop) begin
          next_st = PWR_STOP;
        end else if (go_wait) begin
          next_st = PWR_WAIT;
        end
      end
      PWR_WAIT: begin
        if (sci_irq_req || ext_wake) begin
          next_st = PWR_RUN;
        end
      end
      PWR_STOP: begin
        if (ext_wake) begin
          next_st = PWR_RUN;
        end
      end
      default: next_st = PWR_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= PWR_RUN;
    end else begin
      st <= next_st;
    end
  end

  chk_wait_wake: assert property (@(posedge sys_clk)
    disable iff (rst)
    (st == PWR_WAIT && sci_irq_req) |=> st == PWR_RUN)
    else $error("serial request did not end wait");

  chk_wait_runs: assert property (@(posedge sys_clk)
    disable iff (rst)
    (st == PWR_WAIT && prescale_select == 2'b00) |-> pre_tick)
    else $error("generator idle during wait");

  // --------------------------------------------------------------------
  // stop side effects on the frame logic
  // --------------------------------------------------------------------
  // a receive cut by stop cannot be completed, so it is dropped;
  // a transmit only pauses, its divider phase is kept
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_discard <= 1'b0;
      tx_frozen  <= 1'b0;
    end else begin
      rx_discard <= (st == PWR_RUN) && go_stop && rx_busy;
      if ((st == PWR_RUN) && go_stop && tx_busy) begin
        tx_frozen <= 1'b1;
      end else if (st == PWR_STOP && ext_wake) begin
        tx_frozen <= 1'b0;
      end
    end
  end

  chk_stop_quiet: assert property (@(posedge sys_clk)
    disable iff (rst)
    (st == PWR_STOP) |=> !rx_sample_tick && !tx_bit_tick)
    else $error("tick seen during stop");

  chk_stop_drop: assert property (@(posedge sys_clk)
    disable iff (rst)
    (st == PWR_RUN && go_stop && rx_busy) |=> rx_discard ##1 !rx_discard)
    else $error("partial receive not dropped on stop");

  chk_stop_hold: assert property (@(posedge sys_clk)
    disable iff (rst)
    (st == PWR_STOP ##1 st == PWR_STOP) |-> $stable(ovs_cnt)
    && $stable(pre_cnt)) else $error("tx phase moved in stop");

  chk_stop_resume: assert property (@(posedge sys_clk)
    disable iff (rst)
    (st == PWR_STOP && ext_wake && tx_frozen) |=>
    st == PWR_RUN && !tx_frozen && gen_run)
    else $error("frozen transmit did not resume");

  // --------------------------------------------------------------------
  // interrupt status and mask
  // --------------------------------------------------------------------
  always_comb begin
    ev_set = 4'h0;
    ev_set[`BRG_EV_WAITX]  = (st == PWR_WAIT) && (next_st == PWR_RUN);
    ev_set[`BRG_EV_STOPX]  = (st == PWR_STOP) && (next_st == PWR_RUN);
    ev_set[`BRG_EV_RXDROP] = (st == PWR_RUN) && go_stop && rx_busy;
    ev_set[`BRG_EV_TXFRZ]  = (st == PWR_RUN) && go_stop && tx_busy;
  end

  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_clr  = (rd_take && s_axi_araddr == `BRG_OFS_STAT) ?
                   status : 4'h0;

  // set beats the read clear, so no event is lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status <= 4'h0;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~rd_clr) | ev_set;
      irq    <= |(((status & ~rd_clr) | ev_set) & mask);
    end
  end

  // --------------------------------------------------------------------
  // axi4-lite write channel
  // --------------------------------------------------------------------
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;

  // address and data taken in either order; ready drops until response
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 8'h00;
      w_lane        <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BRG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_full       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_full       <= 1'b1;
        w_data       <= s_axi_wdata[7:0];
        w_lane       <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[1:0] == 2'b00) ?
                        `BRG_RESP_OKAY : `BRG_RESP_SLV;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // rate and mask storage; rate should stay put while serial is on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rate <= `BRG_RATE_RST;
      mask <= 4'h0;
    end else if (wr_fire && w_lane) begin
      if (aw_addr == `BRG_OFS_RATE) begin
        rate <= w_data;
      end
      if (aw_addr == `BRG_OFS_MASK) begin
        mask <= w_data[3:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // axi4-lite read channel
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BRG_RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `BRG_RESP_OKAY;
        unique case (s_axi_araddr)
          `BRG_OFS_RATE: s_axi_rdata <= {24'h00_0000, rate};
          `BRG_OFS_MODE: s_axi_rdata <= {29'h0, st};
          `BRG_OFS_STAT: s_axi_rdata <= {28'h0, status};
          `BRG_OFS_MASK: s_axi_rdata <= {28'h0, mask};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BRG_RESP_SLV;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  chk_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 irq == |($past(status & ~rd_clr | ev_set) & $past(mask)))
    else $error("interrupt level disagrees with status");
endmodule : brg_top
`default_nettype wire

// File: testbench/brg_frame_peer.sv
// frame logic stand-in that keeps the busy levels the generator watches
`timescale 1ns/1ps
`default_nettype none
module brg_frame_peer (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start_tx,
  input  wire logic start_rx,
  input  wire logic tx_bit_tick,
  input  wire logic rx_sample_tick,
  input  wire logic rx_discard,
  output logic      tx_busy,
  output logic      rx_busy
);
  logic [3:0] tx_left;
  logic [7:0] rx_left;

  // ----------------------------------------------------------------------
  // frame counters
  // ----------------------------------------------------------------------
  // ten bit times a frame; counts only on ticks, so a halt freezes it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) tx_left <= 4'h0;
    else if (start_tx) tx_left <= 4'ha;
    else if (tx_bit_tick && tx_left != 4'h0) tx_left <= tx_left - 4'h1;
  end

  // sixteen samples a bit; a drop abandons the frame for good
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) rx_left <= 8'h00;
    else if (rx_discard) rx_left <= 8'h00;
    else if (start_rx) rx_left <= 8'ha0;
    else if (rx_sample_tick && rx_left != 8'h00) rx_left <= rx_left - 8'h01;
  end

  assign tx_busy = (tx_left != 4'h0);
  assign rx_busy = (rx_left != 8'h00);
endmodule : brg_frame_peer
`default_nettype wire

// File: testbench/test_brg_top.sv
// self-checking bench for the rate generator
`timescale 1ns/1ps
`default_nettype none
`include "brg_defs.svh"
module test_brg_top;
  import brg_pkg::*;
  logic                   sys_clk, rst, ext_irq_n, sci_irq_req;
  logic [`BRG_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic                   awvalid, awready, wvalid, wready, bvalid, bready;
  logic                   arvalid, arready, rvalid, rready;
  logic [1:0]             bresp, rresp;
  logic                   tx_busy, rx_busy, start_tx, start_rx;
  logic                   tx_bit_tick, rx_sample_tick, rx_discard;
  logic                   tx_frozen, irq;
  brg_pwr_t               power_state;
  int                     err_count, comparisons, gap, s, k, n;
  int                     pdiv [4] = '{1, 3, 4, 13};

  brg_top u_brg_top (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_irq_n(ext_irq_n),
    .sci_irq_req(sci_irq_req), .tx_busy(tx_busy), .rx_busy(rx_busy),
    .tx_bit_tick(tx_bit_tick), .rx_sample_tick(rx_sample_tick),
    .rx_discard(rx_discard), .tx_frozen(tx_frozen),
    .power_state(power_state), .irq(irq));

  brg_frame_peer u_brg_frame_peer (.sys_clk(sys_clk), .rst(rst),
    .start_tx(start_tx), .start_rx(start_rx), .tx_bit_tick(tx_bit_tick),
    .rx_sample_tick(rx_sample_tick), .rx_discard(rx_discard),
    .tx_busy(tx_busy), .rx_busy(rx_busy));

  // 40 mhz system clock
  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------------
  // checks and bus tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int i;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 100) begin
      check(32'h0, 32'h1);
      wrap_up();
    end
    check({30'h0, bresp}, {30'h0, er});
    // one idle edge, so a following call never re-raises bready at once
    @(posedge sys_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed);
    int i;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (i == 100) begin
      check(32'h0, 32'h1);
      wrap_up();
    end
    check({30'h0, rresp}, 32'h0);
    check(rdata, ed);
    // one idle edge, so a following call never re-raises rready at once
    @(posedge sys_clk);
  endtask : axi_rd

  // spacing of the second and third pulses, past any retune transient
  task automatic tick_gap(input bit use_tx, output int g);
    int i, c, t2;
    c = 0;
    t2 = 0;
    g = 0;
    for (i = 0; i < 40000 && c < 3; i++) begin
      @(posedge sys_clk);
      if ((use_tx ? tx_bit_tick : rx_sample_tick) === 1'b1) begin
        c++;
        if (c == 2) t2 = i;
        if (c == 3) g = i - t2;
      end
    end
    if (c < 3) begin
      check(32'h0, 32'h1);
      wrap_up();
    end
  endtask : tick_gap

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {sci_irq_req, start_tx, start_rx} = '0;
    ext_irq_n = 1'b1;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // reset state and register map
    check(32'(power_state), 32'(PWR_RUN));
    axi_rd(`BRG_OFS_RATE, 32'h3f);
    axi_rd(`BRG_OFS_MODE, 32'h1);
    axi_rd(`BRG_OFS_MASK, 32'h0);
    axi_wr(4'h1, 32'h0, `BRG_RESP_SLV);
    axi_wr(`BRG_OFS_STAT, 32'hf, `BRG_RESP_OKAY);
    axi_rd(`BRG_OFS_STAT, 32'h0);
    // every select, tx and rx set apart; retuned only while idle
    for (s = 0; s < 8; s++) begin
      axi_wr(`BRG_OFS_RATE, {26'h0, 3'(7 - s), 3'(s)}, `BRG_RESP_OKAY);
      tick_gap(1'b0, gap);
      check(32'(gap), 32'h1 << s);
      tick_gap(1'b1, gap);
      check(32'(gap), 32'h10 << (7 - s));
    end
    // every prescaler code under select 1
    for (s = 0; s < 4; s++) begin
      axi_wr(`BRG_OFS_RATE, {24'h0, 2'(s), 6'h09}, `BRG_RESP_OKAY);
      tick_gap(1'b0, gap);
      check(32'(gap), 32'(2 * pdiv[s]));
      tick_gap(1'b1, gap);
      check(32'(gap), 32'(32 * pdiv[s]));
    end
    // wait mode keeps ticking; serial left idle in wait
    axi_wr(`BRG_OFS_RATE, 32'h0, `BRG_RESP_OKAY);
    axi_wr(`BRG_OFS_MASK, 32'h1, `BRG_RESP_OKAY);
    axi_wr(`BRG_OFS_MODE, 32'h1, `BRG_RESP_OKAY);
    axi_rd(`BRG_OFS_MODE, 32'(PWR_WAIT));
    tick_gap(1'b0, gap);
    check(32'(gap), 32'h1);
    sci_irq_req <= 1'b1;
    @(posedge sys_clk);
    sci_irq_req <= 1'b0;
    @(posedge sys_clk);
    check(32'(power_state), 32'(PWR_RUN));
    check({31'h0, irq}, 32'h1);
    axi_rd(`BRG_OFS_STAT, 32'h1);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    // stop with both frames under way, on purpose
    start_tx <= 1'b1;
    start_rx <= 1'b1;
    @(posedge sys_clk);
    start_tx <= 1'b0;
    start_rx <= 1'b0;
    repeat (20) @(posedge sys_clk);
    axi_wr(`BRG_OFS_MODE, 32'h2, `BRG_RESP_OKAY);
    check(32'(power_state), 32'(PWR_STOP));
    check({31'h0, rx_busy}, 32'h0);
    check({31'h0, tx_frozen}, 32'h1);
    k = 0;
    repeat (100) begin
      @(posedge sys_clk);
      if (tx_bit_tick !== 1'b0 || rx_sample_tick !== 1'b0) k++;
    end
    check(32'(k), 32'h0);
    check({31'h0, tx_busy}, 32'h1);
    // external wake resumes the frozen frame
    ext_irq_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    ext_irq_n <= 1'b1;
    check(32'(power_state), 32'(PWR_RUN));
    check({31'h0, tx_frozen}, 32'h0);
    check({31'h0, irq}, 32'h0);
    for (n = 0; n < 300 && tx_busy !== 1'b0; n++) @(posedge sys_clk);
    check({31'h0, tx_busy}, 32'h0);
    axi_rd(`BRG_OFS_STAT, 32'he);
    wrap_up();
  end
endmodule : test_brg_top
`default_nettype wire
